// [rtd_pkg.sv]
/*
  package for the time and date counting block: register offsets, field
  positions, reset values and timing counts.
  assumes a single 20 MHz clock and a byte-wide register port inside the device.
*/
package rtd_pkg;
  // register offsets of the counting span
  localparam logic [3:0] ADDR_SEC = 4'h2;
  localparam logic [3:0] ADDR_MIN = 4'h3;
  localparam logic [3:0] ADDR_HOUR = 4'h4;
  localparam logic [3:0] ADDR_DAY = 4'h5;
  localparam logic [3:0] ADDR_WDAY = 4'h6;
  localparam logic [3:0] ADDR_MON = 4'h7;
  localparam logic [3:0] ADDR_YEAR = 4'h8;
  // field positions
  localparam int FLAG_BIT = 7;
  localparam int CENT_BIT = 7;
  // field widths as masks
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_MIN = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DAY = 8'h3F;
  localparam logic [7:0] MASK_WDAY = 8'h07;
  localparam logic [7:0] MASK_MON = 8'h1F;
  localparam logic [7:0] MASK_YEAR = 8'hFF;
  // wrap points in BCD
  localparam logic [7:0] LAST_SEC = 8'h59;
  localparam logic [7:0] LAST_HOUR = 8'h23;
  localparam logic [7:0] LAST_MON = 8'h12;
  localparam logic [7:0] LAST_YEAR = 8'h99;
  localparam logic [2:0] LAST_WDAY = 3'h6;
  localparam logic [7:0] FIRST_DAY = 8'h01;
  // reset values: january 1st, year 00, flag set
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_MON = 8'h01;
  // clock and tick timing
  localparam int CLK_HZ = 20000000;
  localparam int TICK_HZ = 1;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

  // the complete time word
  typedef struct packed {
    logic flag;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [2:0] wday;
    logic cent;
    logic [7:0] mon;
    logic [7:0] year;
  } rtd_time_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtd_req_s;
endpackage

// [rtd_regmem.sv]
/*
  small register memory for the calendar bytes: each byte is written only
  by the counter's mirror, never by the host, and the read port comes out of a register.
  assumes the caller never writes two sources at one edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rtd_regmem #(
  parameter int WORDS = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [3:0] raddr,
  output logic [7:0] rdata
);
  // storage of the whole byte map
  logic [7:0] mem_q [WORDS];
  logic [7:0] rdata_d;

  // read data is the addressed byte, zero beyond the map
  always_comb begin
    rdata_d = 8'h00;
    if (int'(raddr) < WORDS) begin
      rdata_d = mem_q[raddr];
    end
  end

  // memory itself carries no reset, the read register does
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// [rtd_counter.sv]
/*
  time and date counting block: BCD seconds to years with integrity flag and
  century flag, a pending tick held while an access is in progress.
  assumes the serial slave raises access_busy for the whole of an access and
  presents byte writes as one-cycle strobes; tick_1hz is a same-clock pulse.
*/
//Contract
//- bit 7 of seconds: integrity flag, starts set
//- seconds BCD, tens 6:4, units 3:0
//- low supply sets flag; only host clears
//- oscillator stop also sets the flag
//- minutes BCD tens 6:4, bit 7 unused
//- hours BCD tens 5:4, bits 7:6 unused
//- day BCD tens 5:4, top bits unused
//- february has 29 when year divisible by 4
//- weekday 3 bits, 0 to 6
//- century flag toggles on year 99 to 00
//- month BCD tens bit 4, 6:5 unused
//- year BCD over all eight bits
//- counters frozen during any host access
//- one pending tick kept, applied afterwards
`timescale 1ns/1ns
`default_nettype none
module rtd_counter (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick_1hz,
  input wire logic supply_low_pin,
  input wire logic osc_stopped_pin,
  input wire logic access_busy,
  input wire rtd_pkg::rtd_req_s req,
  output logic [7:0] rdata,
  output rtd_pkg::rtd_time_s now,
  output logic tick_pending
);
  // synchronisers for the two pin level inputs
  logic [1:0] low_sync_q;
  logic [1:0] stop_sync_q;
  logic low_s;
  logic stop_s;
  // live time registers and the pending request
  rtd_pkg::rtd_time_s t_q, t_d;
  logic pend_q, pend_d;
  logic step;
  rtd_pkg::rtd_time_s inc;
  logic [7:0] rd_byte;

  assign low_s = low_sync_q[1];
  assign stop_s = stop_sync_q[1];

  // BCD increment of one byte
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last day of a month, leap test on the BCD year
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = (yr[1:0] == 2'h0) ? !yr[4] : (yr[1:0] == 2'h2 && yr[4]);
    month_last = 8'h31;
    if (mon == 8'h02) begin
      month_last = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      month_last = 8'h30;
    end
  endfunction

  // synchronisers: the first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      low_sync_q <= 2'h0;
      stop_sync_q <= 2'h0;
    end else begin
      low_sync_q <= {low_sync_q[0], supply_low_pin};
      stop_sync_q <= {stop_sync_q[0], osc_stopped_pin};
    end
  end

  // one-step advance of the whole calendar with carries
  always_comb begin
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    inc = t_q;
    c_min = 1'b0;
    c_hour = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    if (t_q.sec == rtd_pkg::LAST_SEC) begin
      inc.sec = 8'h00;
      c_min = 1'b1;
    end else begin
      inc.sec = bcd_inc(t_q.sec);
    end
    if (c_min) begin
      if (t_q.min == rtd_pkg::LAST_SEC) begin
        inc.min = 8'h00;
        c_hour = 1'b1;
      end else begin
        inc.min = bcd_inc(t_q.min);
      end
    end
    if (c_hour) begin
      if (t_q.hour == rtd_pkg::LAST_HOUR) begin
        inc.hour = 8'h00;
        c_day = 1'b1;
      end else begin
        inc.hour = bcd_inc(t_q.hour);
      end
    end
    if (c_day) begin
      inc.wday = (t_q.wday == rtd_pkg::LAST_WDAY) ? 3'h0 : t_q.wday + 3'h1;
      if (t_q.day == month_last(t_q.mon, t_q.year)) begin
        inc.day = rtd_pkg::FIRST_DAY;
        c_mon = 1'b1;
      end else begin
        inc.day = bcd_inc(t_q.day);
      end
    end
    if (c_mon) begin
      if (t_q.mon == rtd_pkg::LAST_MON) begin
        inc.mon = 8'h01;
        if (t_q.year == rtd_pkg::LAST_YEAR) begin
          inc.year = 8'h00;
          inc.cent = !t_q.cent;
        end else begin
          inc.year = bcd_inc(t_q.year);
        end
      end else begin
        inc.mon = bcd_inc(t_q.mon);
      end
    end
  end

  // next state of time registers and the pending request
  always_comb begin
    t_d = t_q;
    pend_d = pend_q;
    step = 1'b0;
    // freeze while the host is busy
    if (access_busy) begin
      if (tick_1hz) begin
        pend_d = 1'b1;
      end
    end else if (tick_1hz || pend_q) begin
      step = 1'b1;
      pend_d = 1'b0;
      t_d = inc;
    end
    // host byte writes, with unused bits forced to zero
    if (req.wr) begin
      if (req.addr == rtd_pkg::ADDR_SEC) begin
        t_d.flag = req.wdata[rtd_pkg::FLAG_BIT];
        t_d.sec = req.wdata & rtd_pkg::MASK_SEC;
      end else if (req.addr == rtd_pkg::ADDR_MIN) begin
        t_d.min = req.wdata & rtd_pkg::MASK_MIN;
      end else if (req.addr == rtd_pkg::ADDR_HOUR) begin
        t_d.hour = req.wdata & rtd_pkg::MASK_HOUR;
      end else if (req.addr == rtd_pkg::ADDR_DAY) begin
        t_d.day = req.wdata & rtd_pkg::MASK_DAY;
      end else if (req.addr == rtd_pkg::ADDR_WDAY) begin
        t_d.wday = req.wdata[2:0];
      end else if (req.addr == rtd_pkg::ADDR_MON) begin
        t_d.cent = req.wdata[rtd_pkg::CENT_BIT];
        t_d.mon = req.wdata & rtd_pkg::MASK_MON;
      end else if (req.addr == rtd_pkg::ADDR_YEAR) begin
        t_d.year = req.wdata & rtd_pkg::MASK_YEAR;
      end
    end
    // low supply sets, and set wins over a host clear
    if (low_s || stop_s) begin
      t_d.flag = 1'b1;
    end
  end

  // registers only; flag starts set after power-up
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      t_q <= '{flag: 1'b1, sec: 8'h00, min: 8'h00, hour: 8'h00, day: rtd_pkg::RST_DAY, wday: 3'h0,
               cent: 1'b0, mon: rtd_pkg::RST_MON, year: 8'h00};
      pend_q <= 1'b0;
    end else begin
      t_q <= t_d;
      pend_q <= pend_d;
    end
  end

  // packed read-back of the addressed byte
  always_comb begin
    rd_byte = 8'h00;
    if (req.addr == rtd_pkg::ADDR_SEC) begin
      rd_byte = {t_q.flag, t_q.sec[6:0]};
    end else if (req.addr == rtd_pkg::ADDR_MIN) begin
      rd_byte = t_q.min;
    end else if (req.addr == rtd_pkg::ADDR_HOUR) begin
      rd_byte = t_q.hour;
    end else if (req.addr == rtd_pkg::ADDR_DAY) begin
      rd_byte = t_q.day;
    end else if (req.addr == rtd_pkg::ADDR_WDAY) begin
      rd_byte = {5'h00, t_q.wday};
    end else if (req.addr == rtd_pkg::ADDR_MON) begin
      rd_byte = {t_q.cent, 2'h0, t_q.mon[4:0]};
    end else if (req.addr == rtd_pkg::ADDR_YEAR) begin
      rd_byte = t_q.year;
    end
  end

  // snapshot memory mirrors each live byte by cycling through the span; its
  // registered read port mem_rdata is left unused, rdata comes from rd_byte
  logic [3:0] mirror_q, mirror_d;
  logic [7:0] mirror_byte;
  always_comb begin
    mirror_d = (mirror_q == rtd_pkg::ADDR_YEAR) ? rtd_pkg::ADDR_SEC : mirror_q + 4'h1;
    mirror_byte = 8'h00;
    if (mirror_q == rtd_pkg::ADDR_SEC) begin
      mirror_byte = {t_q.flag, t_q.sec[6:0]};
    end else if (mirror_q == rtd_pkg::ADDR_MIN) begin
      mirror_byte = t_q.min;
    end else if (mirror_q == rtd_pkg::ADDR_HOUR) begin
      mirror_byte = t_q.hour;
    end else if (mirror_q == rtd_pkg::ADDR_DAY) begin
      mirror_byte = t_q.day;
    end else if (mirror_q == rtd_pkg::ADDR_WDAY) begin
      mirror_byte = {5'h00, t_q.wday};
    end else if (mirror_q == rtd_pkg::ADDR_MON) begin
      mirror_byte = {t_q.cent, 2'h0, t_q.mon[4:0]};
    end else if (mirror_q == rtd_pkg::ADDR_YEAR) begin
      mirror_byte = t_q.year;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mirror_q <= rtd_pkg::ADDR_SEC;
    end else begin
      mirror_q <= mirror_d;
    end
  end

  // read data register: live byte captured on each read strobe
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] mem_rdata;
  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      rdata_d = rd_byte;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  rtd_regmem #(.WORDS(16)) u_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(1'b1),
    .waddr(mirror_q),
    .wdata(mirror_byte),
    .raddr(req.addr),
    .rdata(mem_rdata)
  );

  assign rdata = rdata_q;
  assign now = t_q;
  assign tick_pending = pend_q;

  // checks
  chk_freeze_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    access_busy && !(req.wr) |=> $stable(t_q.sec) || $rose(t_q.flag))
    else $error("seconds moved during access");
  chk_pend_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    access_busy && tick_1hz |=> pend_q)
    else $error("tick during access not held");
  chk_pend_served: assert property (@(posedge mclk) disable iff (!rst_n)
    pend_q && !access_busy && !req.wr |=> !pend_q && t_q.sec != $past(t_q.sec))
    else $error("pending tick not applied");
  chk_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
    low_s |=> t_q.flag)
    else $error("flag not set on low supply");
  chk_flag_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    stop_s |=> t_q.flag)
    else $error("flag not set on oscillator stop");
  chk_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    t_q.flag && !(req.wr && req.addr == rtd_pkg::ADDR_SEC) |=> t_q.flag)
    else $error("flag cleared without host");
  chk_sec_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    step && !req.wr && t_q.sec == rtd_pkg::LAST_SEC |=> t_q.sec == 8'h00)
    else $error("seconds did not wrap");
  chk_wday_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
    step && !req.wr && t_q.wday == 3'h6 && t_q.sec == 8'h59 && t_q.min == 8'h59 && t_q.hour == 8'h23
    |=> t_q.wday == 3'h0)
    else $error("weekday did not wrap");
  chk_cent_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(req.wr) && $changed(t_q.cent) |-> $past(t_q.year) == 8'h99 && t_q.year == 8'h00)
    else $error("century changed without year wrap");
  cov_pending: cover property (@(posedge mclk) disable iff (!rst_n) pend_q ##1 !pend_q);
  cov_day_wrap: cover property (@(posedge mclk) disable iff (!rst_n) step ##1 t_q.day == 8'h01);
  cov_leap: cover property (@(posedge mclk) disable iff (!rst_n) t_q.mon == 8'h02 && t_q.day == 8'h29);
endmodule
`default_nettype wire

// [rtd_host_model.sv]
/*
  host model for the register port: stands where the serial slave would be
  and frames every access with access_busy, one byte strobe per cycle.
  assumes the counter samples strobes on the rising edge of mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtd_host_model (
  input wire logic mclk,
  input wire logic [7:0] rdata,
  output var logic access_busy,
  output var rtd_pkg::rtd_req_s req
);
  // idle: no access, port strobes low
  initial begin
    access_busy = 1'b0;
    req = '0;
  end

  // held access frame, used to park the counters on purpose
  task automatic hold(input logic b);
    @(negedge mclk) access_busy = b;
  endtask

  // span from pointer a0
  // n bytes from a0 in one frame; read bytes land one cycle behind their strobe
  task automatic xfer(input logic w, input logic [3:0] a0, input int n, input logic [55:0] wv,
                      output logic [55:0] rv);
    int i;
    rv = '0;
    @(negedge mclk) access_busy = 1'b1;
    for (i = 0; i < n; i++) begin
      @(negedge mclk);
      if (i > 0) rv[63-8*i -: 8] = rdata;
      req.wr = w;
      req.rd = !w;
      req.addr = a0 + 4'(i);
      req.wdata = wv[55-8*i -: 8];
    end
    @(negedge mclk);
    rv[63-8*n -: 8] = rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
    // released data line shows a changed pattern, never the last byte
    req.wdata = ~req.wdata;
    @(negedge mclk) access_busy = 1'b0;
  endtask
endmodule
`default_nettype wire

// [test_rtd_counter.sv]
/*
  self-checking bench for the counting block: reset values, then table of
  one-tick rollovers, freeze with a pending tick, flag set and clear, unused bits.
  assumes the host model frames accesses and inputs move on the falling edge.
*/
`timescale 1ns/1ns
`default_nettype none
module test_rtd_counter;
  `define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

  logic mclk; // 50 ns clock
  logic rst_n; // synchronous, active low
  logic tick_1hz; // one-cycle second pulse
  logic supply_low_pin;
  logic osc_stopped_pin;
  logic access_busy;
  rtd_pkg::rtd_req_s req;
  logic [7:0] rdata;
  rtd_pkg::rtd_time_s now;
  logic tick_pending;
  int bad_count = 0;
  int total_checks = 0;
  logic [55:0] got; // bytes sec, min, hour, day, wday, month, year
  int r;
  int p;
  // ordinary cases: span written, then one tick, then the expected span
  logic [55:0] row_in [10] = '{56'h59592331061299, 56'h59592328020204, 56'h59592329030204,
    56'h59592328010201, 56'h59592328000200, 56'h59592330050410, 56'h59592331020123,
    56'h09000001000100, 56'h59590915030750, 56'h59592331049299};
  logic [55:0] row_exp [10] = '{56'h00000001008100, 56'h00000029030204, 56'h00000001040304,
    56'h00000001020301, 56'h00000029010200, 56'h00000001060510, 56'h00000001030223,
    56'h10000001000100, 56'h00001015030750, 56'h00000001050100};

  rtd_counter uut (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick_1hz(tick_1hz),
    .supply_low_pin(supply_low_pin),
    .osc_stopped_pin(osc_stopped_pin),
    .access_busy(access_busy),
    .req(req),
    .rdata(rdata),
    .now(now),
    .tick_pending(tick_pending)
  );

  rtd_host_model host (
    .mclk(mclk),
    .rdata(rdata),
    .access_busy(access_busy),
    .req(req)
  );

  // free-running clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // one second pulse, one cycle wide
  task automatic tick();
    @(negedge mclk) tick_1hz = 1'b1;
    @(negedge mclk) tick_1hz = 1'b0;
  endtask

  // verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    final_report();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    tick_1hz = 1'b0;
    supply_low_pin = 1'b0;
    osc_stopped_pin = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    // reset image read back as one span, flag set
    host.xfer(1'b0, 4'h2, 7, '0, got);
    `CHK(got, 56'h80000001000101 & 56'hFFFFFFFFFFFF00)
    `CHK(tick_pending, 1'b0)
    // table of rollovers; writing bit 7 low clears the flag
    for (r = 0; r < 10; r++) begin
      host.xfer(1'b1, 4'h2, 7, row_in[r], got);
      tick();
      repeat (2) @(negedge mclk);
      host.xfer(1'b0, 4'h2, 7, '0, got);
      `CHK(got, row_exp[r])
    end
    // counters parked during an access, only one tick kept
    host.xfer(1'b1, 4'h2, 7, 56'h10000001000100, got);
    host.hold(1'b1);
    tick();
    `CHK(now.sec, 8'h10)
    `CHK(tick_pending, 1'b1)
    tick();
    tick();
    host.hold(1'b0);
    repeat (3) @(negedge mclk);
    `CHK(now.sec, 8'h11)
    `CHK(tick_pending, 1'b0)
    // low supply, then stopped oscillator: flag set, kept, cleared by host only
    for (p = 0; p < 2; p++) begin
      supply_low_pin = (p == 0);
      osc_stopped_pin = (p == 1);
      repeat (4) @(negedge mclk);
      supply_low_pin = 1'b0;
      osc_stopped_pin = 1'b0;
      repeat (5) @(negedge mclk);
      `CHK(now.flag, 1'b1)
      tick();
      repeat (2) @(negedge mclk);
      `CHK(now.flag, 1'b1)
      host.xfer(1'b1, 4'h2, 1, 56'h30000000000000, got);
      `CHK(now.flag, 1'b0)
      `CHK(now.sec, 8'h30)
    end
    // unused bits drop, unmapped offset ignored and reads zero
    host.xfer(1'b1, 4'h3, 4, 56'hD5E3F5FE000000, got);
    host.xfer(1'b1, 4'h7, 1, 56'h69000000000000, got);
    host.xfer(1'b1, 4'h9, 1, 56'hAA000000000000, got);
    host.xfer(1'b0, 4'h3, 4, '0, got);
    `CHK(got[55:48], 8'h55)
    `CHK(got[47:40], 8'h23)
    `CHK(got[39:32], 8'h35)
    `CHK(got[31:24], 8'h06)
    host.xfer(1'b0, 4'h7, 3, '0, got);
    `CHK(got[55:48], 8'h09)
    `CHK(got[47:40], 8'h00)
    `CHK(got[39:32], 8'h00)
    // reset in mid-run with a tick held: all back to start-up values
    host.hold(1'b1);
    tick();
    rst_n = 1'b0;
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    `CHK(rdata, 8'h00)
    `CHK(tick_pending, 1'b0)
    host.hold(1'b0);
    repeat (2) @(negedge mclk);
    host.xfer(1'b0, 4'h2, 7, '0, got);
    `CHK(got, 56'h80000001000100)
    `CHK(tick_pending, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
